// [design/flash_service_pkg.sv]
// Constants for the flash service unit: locations, entry points, keys and counts
`default_nettype none
package flash_service_pkg;
	// Parameter locations in data memory
	localparam logic [7:0] ADDR_LOW_LOC    = 8'h00_A8;
	localparam logic [7:0] ADDR_HIGH_LOC   = 8'h00_A9;
	localparam logic [7:0] READ_RESULT_LOC = 8'h00_AA;
	localparam logic [7:0] WRITE_SRC_LOC   = 8'h00_AB;
	localparam logic [7:0] PULSE_TIME_LOC  = 8'h00_E1;
	localparam logic [7:0] KEY_LOC         = 8'h00_E2;
	localparam logic [7:0] BYTE_COUNT_LOC  = 8'h00_F1;
	// Reset value of every parameter location
	localparam logic [7:0] LOC_RESET       = 8'h00_00;
	// Entry points
	localparam logic [7:0] ENTRY_SERIAL    = 8'h00_00;
	localparam logic [7:0] ENTRY_READ      = 8'h00_11;
	localparam logic [7:0] ENTRY_WRITE     = 8'h00_14;
	localparam logic [7:0] ENTRY_PAGE_ERA  = 8'h00_17;
	localparam logic [7:0] ENTRY_MASS_ERA  = 8'h00_1A;
	localparam logic [7:0] ENTRY_BLOCK_WR  = 8'h00_23;
	localparam logic [7:0] ENTRY_BLOCK_RD  = 8'h00_26;
	localparam logic [7:0] ENTRY_EXIT      = 8'h00_62;
	// Keys
	localparam logic [7:0] CALL_KEY        = 8'h00_98;
	localparam logic [7:0] MASS_CONFIRM    = 8'h00_55;
	// Key lifetime in instruction cycles, age counter saturates at 7
	localparam logic [2:0] KEY_WINDOW      = 3'h6;
	// Largest block write length
	localparam logic [7:0] BLOCK_WR_MAX    = 8'h00_10;
	// Watchdog service interval inside the upper window, instruction cycles
	localparam logic [11:0] WDOG_KICK_CYCLES = 12'h03E8;
	// Flash command codes
	typedef enum logic [1:0] {
		FL_READ  = 2'h0,
		FL_WRITE = 2'h1,
		FL_PAGE  = 2'h2,
		FL_MASS  = 2'h3
	} flash_cmd_type;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_SINGLE = 6'b00_0010,
		ST_BLOCK  = 6'b00_0100,
		ST_RETURN = 6'b00_1000,
		ST_SERIAL = 6'b01_0000,
		ST_RESET  = 6'b10_0000
	} seq_state_type;
endpackage : flash_service_pkg
`default_nettype wire

// [design/flash_service_unit.sv]
// Flash service sequencer with its transfer FIFO
// Function
// - Page-erase entry erases the page at the two address locations.
// - Mass-erase entry erases all flash only with 0x55 in the accumulator.
// - After a mass erase, enter serial programming mode, never return.
// - Read-byte entry stores the addressed flash byte in the read-result location.
// - Block-read copies count flash bytes to RAM at X, count 0 to 255.
// - Write-byte entry programs the write-source byte at the given address.
// - Block-write programs count RAM bytes from X into flash, count 0 to 16.
// - Exit entry resets the device, no return to caller.
// - Base entry enters serial mode until serial exit, which resets.
// - A jump is accepted only within six cycles of the key write.
// - Flash address comes from two locations, high byte at the upper one.
// - Block length comes from the byte-count location.
// - Interrupts suppressed while servicing, global enable left untouched.
// - Watchdog kicked periodically during service and again on return.
`default_nettype none
`timescale 1ns/1ps

// Synchronous FIFO, valid/ready on both sides
module transfer_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             clkEnable,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PW:0]      wrPtr;
	logic [PW:0]      rdPtr;
	wire              doPush = clkEnable && inValid && inReady;
	wire              doPop  = clkEnable && outValid && outReady;

	// Extra pointer bit tells full from empty
	assign inReady  = !((wrPtr[PW-1:0] == rdPtr[PW-1:0]) && (wrPtr[PW] != rdPtr[PW]));
	assign outValid = (wrPtr != rdPtr);
	assign outData  = store[rdPtr[PW-1:0]];

	// Pointers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (doPush) wrPtr <= wrPtr + 1'b1;
			if (doPop) rdPtr <= rdPtr + 1'b1;
		end
	end

	// Storage carries no reset
	always_ff @(posedge sys_clk) begin
		if (doPush) store[wrPtr[PW-1:0]] <= inData;
	end
endmodule : transfer_fifo

// Sequencer reached through the jump-to-boot call
module flash_service_unit (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        clkEnable,
	input  wire logic        locWrite,
	input  wire logic        locRead,
	input  wire logic [7:0]  locAddr,
	input  wire logic [7:0]  locWrData,
	output logic      [7:0]  locRdData,
	input  wire logic        jumpToBootService,
	input  wire logic [7:0]  jumpTarget,
	input  wire logic [7:0]  accumulator,
	input  wire logic [7:0]  xPointer,
	input  wire logic [7:0]  dataSegment,
	input  wire logic        serialExit,
	output logic             flashReq,
	output flash_service_pkg::flash_cmd_type flashCmd,
	output logic      [15:0] flashAddr,
	output logic      [7:0]  flashWrData,
	input  wire logic        flashDone,
	input  wire logic [7:0]  flashRdData,
	output logic      [7:0]  programPulseTiming,
	output logic             ramReq,
	output logic             ramWe,
	output logic      [15:0] ramAddr,
	output logic      [7:0]  ramWrData,
	input  wire logic        ramAck,
	input  wire logic [7:0]  ramRdData,
	output logic             serviceBusy,
	output logic             irqSuppress,
	output logic             watchdogKick,
	output logic             returnToFlash,
	output logic             jumpRejected,
	output logic             serialProgMode,
	output logic             deviceResetReq
);
	flash_service_pkg::seq_state_type state;
	logic [7:0]  addrLow;
	logic [7:0]  addrHigh;
	logic [7:0]  readResult;
	logic [7:0]  writeSource;
	logic [7:0]  keyValue;
	logic [7:0]  byteCount;
	logic [2:0]  keyAge;
	logic        keyArmed;
	logic [11:0] wdogCount;
	logic        blockToFlash;
	logic [7:0]  srcIndex;
	logic [7:0]  dstIndex;
	logic [7:0]  blockLength;
	logic        srcPending;
	logic        dstPending;
	logic [7:0]  fifoOutData;
	logic        fifoInReady;
	logic        fifoOutValid;

	// Call decode
	wire keyFresh   = keyArmed && (keyAge < flash_service_pkg::KEY_WINDOW);
	wire callTaken  = clkEnable && jumpToBootService && (state == flash_service_pkg::ST_IDLE);
	wire callOk     = callTaken && keyFresh;
	wire isRead     = jumpTarget == flash_service_pkg::ENTRY_READ;
	wire isWrite    = jumpTarget == flash_service_pkg::ENTRY_WRITE;
	wire isPage     = jumpTarget == flash_service_pkg::ENTRY_PAGE_ERA;
	wire isMass     = (jumpTarget == flash_service_pkg::ENTRY_MASS_ERA)
	                  && (accumulator == flash_service_pkg::MASS_CONFIRM);
	wire isBlockWr  = jumpTarget == flash_service_pkg::ENTRY_BLOCK_WR;
	wire isBlockRd  = jumpTarget == flash_service_pkg::ENTRY_BLOCK_RD;
	wire isExit     = jumpTarget == flash_service_pkg::ENTRY_EXIT;
	wire isSerial   = jumpTarget == flash_service_pkg::ENTRY_SERIAL;
	wire isSingle   = isRead || isWrite || isPage || isMass;
	wire knownEntry = isSingle || isBlockWr || isBlockRd || isExit || isSerial;
	wire [15:0] baseAddr = {addrHigh, addrLow};

	// Block-write length is clamped to the largest legal count
	wire [7:0] wrLength = (byteCount > flash_service_pkg::BLOCK_WR_MAX)
	                      ? flash_service_pkg::BLOCK_WR_MAX : byteCount;
	wire [7:0] startLength = isBlockWr ? wrLength : byteCount;

	// Block data path: source fills the FIFO, sink drains it
	wire inBlock    = state == flash_service_pkg::ST_BLOCK;
	wire srcAck     = blockToFlash ? ramAck : flashDone;
	wire [7:0] srcData = blockToFlash ? ramRdData : flashRdData;
	wire dstAck     = blockToFlash ? flashDone : ramAck;
	wire srcIssue   = clkEnable && inBlock && !srcPending && (srcIndex != blockLength) && fifoInReady;
	wire srcReturn  = clkEnable && inBlock && srcPending && srcAck;
	wire dstIssue   = clkEnable && inBlock && !dstPending && fifoOutValid;
	wire dstReturn  = clkEnable && inBlock && dstPending && dstAck;
	wire blockEnd   = inBlock && (dstIndex == blockLength) && !srcPending && !dstPending;
	wire singleEnd  = clkEnable && (state == flash_service_pkg::ST_SINGLE) && flashDone;
	wire wdogDue    = wdogCount == flash_service_pkg::WDOG_KICK_CYCLES;

	// Space was checked at issue and only one fetch is outstanding, so a push never stalls
	transfer_fifo #(
		.WIDTH (8),
		.DEPTH (8)
	) fifo_inst (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.clkEnable (clkEnable),
		.inData    (srcData),
		.inValid   (srcReturn),
		.inReady   (fifoInReady),
		.outData   (fifoOutData),
		.outValid  (fifoOutValid),
		.outReady  (dstIssue)
	);

	// Parameter locations; the processor can write them at any time, also while the unit runs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			addrLow            <= flash_service_pkg::LOC_RESET;
			addrHigh           <= flash_service_pkg::LOC_RESET;
			writeSource        <= flash_service_pkg::LOC_RESET;
			programPulseTiming <= flash_service_pkg::LOC_RESET;
			keyValue           <= flash_service_pkg::LOC_RESET;
			byteCount          <= flash_service_pkg::LOC_RESET;
		end else if (clkEnable && locWrite) begin
			case (locAddr)
				flash_service_pkg::ADDR_LOW_LOC:   addrLow <= locWrData;
				flash_service_pkg::ADDR_HIGH_LOC:  addrHigh <= locWrData;
				flash_service_pkg::WRITE_SRC_LOC:  writeSource <= locWrData;
				flash_service_pkg::PULSE_TIME_LOC: programPulseTiming <= locWrData;
				flash_service_pkg::KEY_LOC:        keyValue <= locWrData;
				flash_service_pkg::BYTE_COUNT_LOC: byteCount <= locWrData;
				default: ;
			endcase
		end
	end

	// Key age: a fresh key write beats the expiry of a consumed one
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			keyAge   <= 3'h7;
			keyArmed <= 1'b0;
		end else if (clkEnable) begin
			if (locWrite && (locAddr == flash_service_pkg::KEY_LOC)) begin
				keyArmed <= (locWrData == flash_service_pkg::CALL_KEY);
				keyAge   <= 3'h0;
			end else begin
				if (callTaken) keyArmed <= 1'b0;
				if (keyAge != 3'h7) keyAge <= keyAge + 3'h1;
			end
		end
	end

	// Registered read-back of every location
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			locRdData <= flash_service_pkg::LOC_RESET;
		end else if (clkEnable && locRead) begin
			case (locAddr)
				flash_service_pkg::ADDR_LOW_LOC:    locRdData <= addrLow;
				flash_service_pkg::ADDR_HIGH_LOC:   locRdData <= addrHigh;
				flash_service_pkg::READ_RESULT_LOC: locRdData <= readResult;
				flash_service_pkg::WRITE_SRC_LOC:   locRdData <= writeSource;
				flash_service_pkg::PULSE_TIME_LOC:  locRdData <= programPulseTiming;
				flash_service_pkg::KEY_LOC:         locRdData <= keyValue;
				flash_service_pkg::BYTE_COUNT_LOC:  locRdData <= byteCount;
				default:                            locRdData <= flash_service_pkg::LOC_RESET;
			endcase
		end
	end

	// Sequencer; a rejected call leaves every location alone
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state        <= flash_service_pkg::ST_IDLE;
			jumpRejected <= 1'b0;
			blockToFlash <= 1'b0;
			blockLength  <= 8'h00;
		end else if (clkEnable) begin
			jumpRejected <= callTaken && !(keyFresh && knownEntry);
			case (state)
				flash_service_pkg::ST_IDLE: begin
					if (callOk && isSingle) state <= flash_service_pkg::ST_SINGLE;
					else if (callOk && (isBlockWr || isBlockRd)) begin
						state        <= flash_service_pkg::ST_BLOCK;
						blockToFlash <= isBlockWr;
						blockLength  <= startLength;
					end
					else if (callOk && isExit) state <= flash_service_pkg::ST_RESET;
					else if (callOk && isSerial) state <= flash_service_pkg::ST_SERIAL;
				end
				flash_service_pkg::ST_SINGLE: begin
					if (flashDone && flashCmd == flash_service_pkg::FL_MASS)
						state <= flash_service_pkg::ST_SERIAL;
					else if (flashDone) state <= flash_service_pkg::ST_RETURN;
				end
				flash_service_pkg::ST_BLOCK: begin
					if (blockEnd) state <= flash_service_pkg::ST_RETURN;
				end
				flash_service_pkg::ST_RETURN: state <= flash_service_pkg::ST_IDLE;
				flash_service_pkg::ST_SERIAL: begin
					if (serialExit) state <= flash_service_pkg::ST_RESET;
				end
				flash_service_pkg::ST_RESET: state <= flash_service_pkg::ST_RESET;
				default: state <= flash_service_pkg::ST_IDLE;
			endcase
		end
	end

	// Status outputs; interrupts held off, global enable is not ours to touch
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			serviceBusy    <= 1'b0;
			irqSuppress    <= 1'b0;
			returnToFlash  <= 1'b0;
			serialProgMode <= 1'b0;
			deviceResetReq <= 1'b0;
		end else if (clkEnable) begin
			// A keyed jump to no entry point is refused and must not look busy
			serviceBusy    <= (state != flash_service_pkg::ST_IDLE) || (callOk && knownEntry);
			irqSuppress    <= (state != flash_service_pkg::ST_IDLE) || (callOk && knownEntry);
			returnToFlash  <= state == flash_service_pkg::ST_RETURN;
			serialProgMode <= state == flash_service_pkg::ST_SERIAL;
			deviceResetReq <= state == flash_service_pkg::ST_RESET;
		end
	end

	// Watchdog kick on the interval while busy and once on return
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wdogCount    <= 12'h000;
			watchdogKick <= 1'b0;
		end else if (clkEnable) begin
			watchdogKick <= wdogDue || (state == flash_service_pkg::ST_RETURN);
			if (state == flash_service_pkg::ST_IDLE || wdogDue) wdogCount <= 12'h000;
			else wdogCount <= wdogCount + 12'h001;
		end
	end

	// Flash port: single operations launch at the call, block ones per byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flashReq    <= 1'b0;
			flashCmd    <= flash_service_pkg::FL_READ;
			flashAddr   <= 16'h0000;
			flashWrData <= 8'h00;
		end else if (clkEnable) begin
			flashReq <= 1'b0;
			if (state == flash_service_pkg::ST_IDLE && callOk && isSingle) begin
				flashReq  <= 1'b1;
				flashAddr <= baseAddr;
				flashWrData <= writeSource;
				if (isRead) flashCmd <= flash_service_pkg::FL_READ;
				else if (isWrite) flashCmd <= flash_service_pkg::FL_WRITE;
				else if (isPage) flashCmd <= flash_service_pkg::FL_PAGE;
				else flashCmd <= flash_service_pkg::FL_MASS;
			end else if (blockToFlash ? dstIssue : srcIssue) begin
				flashReq    <= 1'b1;
				flashCmd    <= blockToFlash ? flash_service_pkg::FL_WRITE : flash_service_pkg::FL_READ;
				flashAddr   <= baseAddr + {8'h00, blockToFlash ? dstIndex : srcIndex};
				flashWrData <= fifoOutData;
			end
		end
	end

	// Read result lands in its location when the flash answers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) readResult <= flash_service_pkg::LOC_RESET;
		else if (singleEnd && flashCmd == flash_service_pkg::FL_READ) readResult <= flashRdData;
		else if (clkEnable && locWrite && locAddr == flash_service_pkg::READ_RESULT_LOC) readResult <= locWrData;
	end

	// RAM port, addressed through the caller's data segment
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ramReq    <= 1'b0;
			ramWe     <= 1'b0;
			ramAddr   <= 16'h0000;
			ramWrData <= 8'h00;
		end else if (clkEnable) begin
			ramReq <= 1'b0;
			if (blockToFlash ? srcIssue : dstIssue) begin
				ramReq    <= 1'b1;
				ramWe     <= !blockToFlash;
				ramAddr   <= {dataSegment, xPointer + (blockToFlash ? srcIndex : dstIndex)};
				ramWrData <= fifoOutData;
			end
		end
	end

	// Block progress counters
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			srcIndex   <= 8'h00;
			dstIndex   <= 8'h00;
			srcPending <= 1'b0;
			dstPending <= 1'b0;
		end else if (clkEnable) begin
			if (state == flash_service_pkg::ST_IDLE) begin
				srcIndex <= 8'h00;
				dstIndex <= 8'h00;
			end else begin
				if (srcIssue) srcIndex <= srcIndex + 8'h01;
				if (dstIssue) dstIndex <= dstIndex + 8'h01;
			end
			if (srcIssue) srcPending <= 1'b1;
			else if (srcReturn) srcPending <= 1'b0;
			if (dstIssue) dstPending <= 1'b1;
			else if (dstReturn) dstPending <= 1'b0;
		end
	end
endmodule : flash_service_unit
`default_nettype wire

// [testbench/flash_service_monitor.sv]
// Port checker for the flash service unit
`timescale 1ns/1ps
`default_nettype none
module flash_service_monitor (
	input wire logic                             sys_clk,
	input wire logic                             reset_n,
	input wire logic                             clkEnable,
	input wire logic                             locWrite,
	input wire logic [7:0]                       locAddr,
	input wire logic [7:0]                       locWrData,
	input wire logic                             serialExit,
	input wire logic                             flashReq,
	input wire flash_service_pkg::flash_cmd_type flashCmd,
	input wire logic [15:0]                      flashAddr,
	input wire logic [7:0]                       programPulseTiming,
	input wire logic                             ramReq,
	input wire logic                             serviceBusy,
	input wire logic                             irqSuppress,
	input wire logic                             watchdogKick,
	input wire logic                             returnToFlash,
	input wire logic                             jumpRejected,
	input wire logic                             serialProgMode,
	input wire logic                             deviceResetReq
);
	logic [7:0] hiShadow;
	logic [7:0] loShadow;
	// Mirror of the address pair; the unit itself never writes it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hiShadow <= 8'h00;
			loShadow <= 8'h00;
		end else if (clkEnable && locWrite && locAddr == flash_service_pkg::ADDR_HIGH_LOC) begin
			hiShadow <= locWrData;
		end else if (clkEnable && locWrite && locAddr == flash_service_pkg::ADDR_LOW_LOC) begin
			loShadow <= locWrData;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_irq_follows_busy: assert property (irqSuppress == serviceBusy)
		else $error("irq hold differs from busy");
	a_return_kicks_dog: assert property (returnToFlash |-> watchdogKick)
		else $error("no watchdog kick on return");
	a_return_ends_busy: assert property (returnToFlash && clkEnable |=> !serviceBusy)
		else $error("busy after return");
	a_reject_stays_idle: assert property (jumpRejected |-> !serviceBusy && !flashReq && !ramReq)
		else $error("refused call started work");
	a_serial_no_return: assert property (serialProgMode |-> !returnToFlash)
		else $error("return while in serial mode");
	a_serial_holds: assert property (serialProgMode && !(serialExit && clkEnable) && !$past(serialExit && clkEnable)
		|=> serialProgMode)
		else $error("serial mode dropped");
	a_serial_exit_reset: assert property (serialProgMode && serialExit && clkEnable |-> ##[1:3] deviceResetReq)
		else $error("no reset after serial exit");
	a_reset_sticky: assert property (deviceResetReq |=> deviceResetReq)
		else $error("reset request dropped");
	a_timing_loc: assert property (clkEnable && locWrite && locAddr == flash_service_pkg::PULSE_TIME_LOC
		|=> programPulseTiming == $past(locWrData))
		else $error("pulse timing not updated");
	a_first_addr: assert property ($rose(serviceBusy) && flashReq |-> flashAddr == {hiShadow, loShadow})
		else $error("flash address not from locations");
	a_req_one_cycle: assert property (flashReq && clkEnable |=> !flashReq)
		else $error("flash request longer than one cycle");
	c_return: cover property (returnToFlash);
	c_reject: cover property (jumpRejected);
	c_serial_exit: cover property (serialProgMode && serialExit);
endmodule : flash_service_monitor
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the flash service unit with flash and RAM responders
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        sys_clk = 1'b0, reset_n = 1'b0, clkEnable = 1'b1, locWrite = 1'b0, locRead = 1'b0;
	logic [7:0]  locAddr = 8'h00, locWrData = 8'h00, jumpTarget = 8'h00, accumulator = 8'h00;
	logic [7:0]  xPointer = 8'h00, dataSegment = 8'h00, flashRdData = 8'h00, ramRdData = 8'h00;
	logic        jumpToBootService = 1'b0, serialExit = 1'b0, flashDone = 1'b0, ramAck = 1'b0;
	logic        flashReq, ramReq, ramWe, serviceBusy, irqSuppress, watchdogKick;
	logic        returnToFlash, jumpRejected, serialProgMode, deviceResetReq;
	logic [15:0] flashAddr, ramAddr;
	logic [7:0]  locRdData, flashWrData, programPulseTiming, ramWrData, rd;
	flash_service_pkg::flash_cmd_type flashCmd;
	logic [7:0]  flashMem [int];
	logic [7:0]  ramMem [int];
	logic [7:0]  locs [7] = '{8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hF1, 8'hE2, 8'hE1};
	logic [7:0]  tgt [4] = '{8'h11, 8'h11, 8'h30, 8'h1A};
	logic [7:0]  key [4] = '{8'h98, 8'h97, 8'h98, 8'h98};
	logic [7:0]  term [3] = '{8'h1A, 8'h00, 8'h62};
	int          error_cnt = 0, n_checks = 0, fWait = 0, rWait = 0, opCnt = 0, kicks = 0, slow = 0;
	logic [15:0] lastCmd, lastAddr;
	int          rAddr, rWe, res, base, n, x;

	flash_service_unit u_dut (.*);

	// Free-running instruction clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// Address-derived pattern where nothing was programmed
	function automatic logic [7:0] fByte(input int a);
		return flashMem.exists(a) ? flashMem[a] : 8'(a ^ (a >> 8) ^ 8'h5A);
	endfunction : fByte

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	// Flash and RAM sides answer after a random stall; slow stretches flash to test the watchdog
	always @(negedge sys_clk) begin
		if (watchdogKick === 1'b1) kicks++;
		// Each strobe written once per edge, high on the last stall cycle
		flashDone = (fWait == 1);
		ramAck = (rWait == 1);
		if (fWait > 0) begin
			fWait--;
			if (fWait == 0) begin
				flashRdData = fByte(lastAddr);
				if (lastCmd == 16'd1) flashMem[lastAddr] = flashWrData;
			end
		end else if (flashReq === 1'b1) begin
			fWait = slow + 1 + $urandom_range(3);
			lastCmd = 16'(flashCmd);
			lastAddr = flashAddr;
			opCnt++;
		end
		if (rWait > 0) begin
			rWait--;
			if (rWait == 0) begin
				ramRdData = ramMem.exists(rAddr) ? ramMem[rAddr] : 8'h00;
				if (rWe == 1) ramMem[rAddr] = ramWrData;
			end
		end else if (ramReq === 1'b1) begin
			rWait = 1 + $urandom_range(2);
			rAddr = int'(ramAddr);
			rWe = int'(ramWe);
		end
	end

	task automatic doReset();
		@(negedge sys_clk);
		reset_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
	endtask : doReset

	task automatic locWr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		locWrite = 1'b1;
		locAddr = a;
		locWrData = d;
		@(negedge sys_clk);
		locWrite = 1'b0;
	endtask : locWr

	task automatic locRd(input logic [7:0] a);
		@(negedge sys_clk);
		locRead = 1'b1;
		locAddr = a;
		@(negedge sys_clk);
		locRead = 1'b0;
		rd = locRdData;
	endtask : locRd

	task automatic setup(input int a, input int cnt);
		locWr(8'hA9, 8'(a >> 8));
		locWr(8'hA8, 8'(a));
		locWr(8'hF1, 8'(cnt));
		opCnt = 0;
	endtask : setup

	// Key write, gap+1 idle cycles, jump; res 1 return, 2 refused, 3 serial mode, 4 reset
	task automatic call(input logic [7:0] t, input logic [7:0] k, input int gap, input logic [7:0] acc);
		locWr(8'hE2, k);
		repeat (gap + 1) @(negedge sys_clk);
		jumpToBootService = 1'b1;
		jumpTarget = t;
		accumulator = acc;
		@(negedge sys_clk);
		jumpToBootService = 1'b0;
		res = 0;
		for (int i = 0; i < 3000 && res == 0; i++) begin
			if (returnToFlash === 1'b1) res = 1;
			else if (jumpRejected === 1'b1) res = 2;
			else if (serialProgMode === 1'b1) res = 3;
			else if (deviceResetReq === 1'b1) res = 4;
			else @(negedge sys_clk);
		end
		if (res == 0) begin
			error_cnt++;
			$display("[ERR] %0t call hung", $time);
			summarize();
		end
	endtask : call

	// Hang guard
	initial begin
		#900000;
		error_cnt++;
		$display("[ERR] %0t run limit", $time);
		summarize();
	end

	initial begin
		x = $urandom(8481);
		doReset();
		// Frozen clock enable must ignore a write
		@(negedge sys_clk);
		clkEnable = 1'b0;
		locWr(8'hA8, 8'h3C);
		clkEnable = 1'b1;
		// Reset value and readback of every location, then an unmapped one
		foreach (locs[i]) begin
			locRd(locs[i]);
			chk(rd, 16'h0, "reset value");
			x = $urandom_range(255);
			locWr(locs[i], 8'(x));
			locRd(locs[i]);
			chk(rd, 16'(x), "readback");
		end
		chk(programPulseTiming, 16'(x), "timing port");
		locWr(8'hC0, 8'h77);
		locRd(8'hC0);
		chk(rd, 16'h0, "unmapped");
		// Single read at the oldest accepted key age, then write and a slow page erase
		base = $urandom_range(16'h1FFF);
		setup(base, 0);
		call(flash_service_pkg::ENTRY_READ, flash_service_pkg::CALL_KEY, 4, 8'h00);
		chk(16'(res), 16'd1, "read return");
		chk(16'(lastCmd), 16'd0, "read cmd");
		chk(16'(lastAddr), 16'(base), "read addr");
		locRd(8'hAA);
		chk(rd, fByte(base), "read data");
		x = $urandom_range(255);
		locWr(8'hAB, 8'(x));
		call(flash_service_pkg::ENTRY_WRITE, flash_service_pkg::CALL_KEY, $urandom_range(4), 8'h00);
		chk(16'(lastCmd), 16'd1, "write cmd");
		chk(fByte(base), 16'(x), "write data");
		slow = 1200;
		kicks = 0;
		call(flash_service_pkg::ENTRY_PAGE_ERA, flash_service_pkg::CALL_KEY, 0, 8'h00);
		slow = 0;
		// Let the responder count the return kick before looking
		@(negedge sys_clk);
		chk(16'(lastCmd), 16'd2, "page cmd");
		chk(16'(lastAddr), 16'(base), "page addr");
		chk(16'(kicks >= 2), 16'd1, "watchdog kicks");
		// Stale key, wrong key, unknown entry, bad confirm: all refused, nothing touched
		for (int i = 0; i < 4; i++) begin
			opCnt = 0;
			call(tgt[i], key[i], i == 0 ? 5 : 0, 8'h54);
			chk(16'(res), 16'd2, "refused");
			chk(16'(opCnt), 16'd0, "no flash op");
		end
		locRd(8'hA8);
		chk(rd, 16'(base & 8'hFF), "params kept");
		// Block reads: empty, then random length with X from 220 to 255, wrapping when X plus length passes 256
		for (int j = 0; j < 2; j++) begin
			n = j * $urandom_range(20, 40);
			base = $urandom_range(16'h1F00);
			x = $urandom_range(220, 255);
			xPointer = 8'(x);
			dataSegment = 8'($urandom_range(255));
			setup(base, n);
			call(flash_service_pkg::ENTRY_BLOCK_RD, flash_service_pkg::CALL_KEY, 0, 8'h00);
			chk(16'(opCnt), 16'(n), "block read count");
			for (int i = 0; i < n; i++) chk(ramMem[{dataSegment, 8'(x + i)}], fByte(base + i), "block read");
		end
		// Block writes of 16 and of 20, the latter clamped
		for (int j = 0; j < 2; j++) begin
			n = 16 + 4 * j;
			base = 64 * $urandom_range(120);
			x = $urandom_range(255);
			xPointer = 8'(x);
			for (int i = 0; i < 20; i++) ramMem[{dataSegment, 8'(x + i)}] = 8'($urandom_range(255));
			setup(base, n);
			call(flash_service_pkg::ENTRY_BLOCK_WR, flash_service_pkg::CALL_KEY, 0, 8'h00);
			chk(16'(opCnt), 16'd16, "block write count");
			for (int i = 0; i < 16; i++) chk(fByte(base + i), ramMem[{dataSegment, 8'(x + i)}], "block write");
		end
		// Mass erase, serial start and exit never return to the caller
		for (int j = 0; j < 3; j++) begin
			call(term[j], flash_service_pkg::CALL_KEY, 0, flash_service_pkg::MASS_CONFIRM);
			chk(16'(res), j == 2 ? 16'd4 : 16'd3, "terminal entry");
			if (j == 0) chk(16'(lastCmd), 16'd3, "mass cmd");
			if (res == 3) begin
				repeat (5) @(negedge sys_clk);
				chk(serialProgMode, 16'd1, "serial held");
				serialExit = 1'b1;
				@(negedge sys_clk);
				serialExit = 1'b0;
				repeat (3) @(negedge sys_clk);
			end
			chk(deviceResetReq, 16'd1, "reset request");
			doReset();
		end
		summarize();
	end
endmodule : tb

bind flash_service_unit flash_service_monitor u_mon (.*);
`default_nettype wire
